// ---- logic/clock_source_pkg.sv ----
package clock_source_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET    = 8'hf8;
  localparam logic [7:0] STATUS_OFFSET = 8'hfc;
  localparam logic [7:0] CFG_RESET     = 8'h00;

  // clock configuration fields
  localparam int unsigned BIT_RESUME_LONG = 7;
  localparam int unsigned WAKE_PERIOD_MSB = 6;
  localparam int unsigned WAKE_PERIOD_LSB = 4;
  localparam int unsigned BIT_LV_DISABLE  = 3;
  localparam int unsigned BIT_USB_TUNE    = 2;
  localparam int unsigned BIT_CLKOUT_OFF  = 1;
  localparam int unsigned BIT_EXT_SEL     = 0;

  // status fields
  localparam int unsigned SB_EXT_MODE  = 0;
  localparam int unsigned SB_CPU_RUN   = 1;
  localparam int unsigned SB_PENDING   = 2;
  localparam int unsigned SB_AUX_PIN   = 3;
  localparam int unsigned SB_LV_ACTIVE = 4;
  localparam int unsigned SB_USB_TUNE  = 5;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned RESUME_LONG_MS  = 4;
  localparam int unsigned RESUME_SHORT_US = 128;
  localparam int unsigned INT_WAKE_US     = 8;
  localparam int unsigned START_US        = 1000;

  // microseconds to whole clock cycles, never below one cycle
  function automatic logic [31:0] us_to_cycles(input int unsigned us);
    logic [31:0] c;
    c = 32'(us * CLK_MHZ);
    return (c == 32'h0000_0000) ? 32'h0000_0001 : c;
  endfunction

  localparam logic [31:0] RESUME_LONG_CYC  = us_to_cycles(RESUME_LONG_MS * 1000);
  localparam logic [31:0] RESUME_SHORT_CYC = us_to_cycles(RESUME_SHORT_US);
  localparam logic [31:0] INT_WAKE_CYC     = us_to_cycles(INT_WAKE_US);
  localparam logic [31:0] START_CYC        = us_to_cycles(START_US);

  // ---------------------------------------------------------------
  // clock control sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SUSPENDED,
    ST_WAIT_STABLE,
    ST_DELAY,
    ST_LV_HOLD
  } clk_state_t;

endpackage

// ---- logic/delay_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module delay_counter
  import clock_source_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  // status
  output logic             busy,
  output logic             expire
);

  logic [31:0] cnt_q;
  logic        busy_q;
  logic        expire_q;
  wire         at_zero = (cnt_q == 32'h0000_0000);

  // ---------------------------------------------------------------
  // down counter, a new load restarts it at any time
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 32'h0000_0000;
      busy_q   <= 1'b0;
      expire_q <= 1'b0;
    end else if (load) begin
      cnt_q    <= (load_value == 32'h0000_0000) ? 32'h0000_0000 : load_value - 32'h0000_0001;
      busy_q   <= 1'b1;
      expire_q <= 1'b0;
    end else begin
      cnt_q    <= at_zero ? cnt_q : cnt_q - 32'h0000_0001;
      busy_q   <= busy_q & ~at_zero;
      expire_q <= busy_q & at_zero;  // one-cycle pulse
    end
  end

  assign busy   = busy_q;
  assign expire = expire_q;

endmodule
`default_nettype wire

// ---- logic/clock_source_config_control.sv ----
// Operation
// R1: resume bit picks 4 ms or 128 us
// R2: internal-oscillator wake waits only 8 us
// R3: bits 6:4 set wake period, gated irq
// R4: bit 3 set turns undervoltage monitor off
// R5: undervoltage holds start-up interval, restart at zero
// R6: bit 2 tunes internal clock on USB traffic
// R7: bit 1 parks output pin high, internal mode
// R8: bit 0 set switches to external, halts cpu
// R9: clearing bit 0 only matters at wake
// R10: after stable clock, extra delay then release
// R11: return to internal only at wake
// R12: reset runs internal, clock driven out
// R13: input pin readable, internal mode, no interrupt
// R14: ready clock goes into input pin only
// R15: watchdog clears select; undervoltage forces internal
// R16: cpu stalled until delay expires, then released
`timescale 1ns/1ps
`default_nettype none
module clock_source_config_control
  import clock_source_pkg::*;
#(
  parameter logic [31:0] RESUME_LONG_CYCLES  = RESUME_LONG_CYC,
  parameter logic [31:0] RESUME_SHORT_CYCLES = RESUME_SHORT_CYC,
  parameter logic [31:0] START_CYCLES        = START_CYC
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // same-domain system events
  input  wire logic        suspend_enter,
  input  wire logic        wake_event,
  input  wire logic        watchdog_reset_event,
  input  wire logic        usb_traffic_rx,
  input  wire logic        wake_timer_tick,
  input  wire logic        wake_irq_enable,
  // asynchronous pins and analog flags
  input  wire logic        undervoltage_below,
  input  wire logic        brownout_reset_event,
  input  wire logic        ext_clock_stable,
  input  wire logic        osc_in_pin,
  input  wire logic        int_clk_level,
  // processor control
  output logic             cpu_run,
  output logic             restart_pulse,
  output logic             partial_suspend,
  // oscillator control
  output logic             int_osc_enable,
  output logic             ext_osc_enable,
  output logic             ext_clk_select,
  output logic             osc_out_pin_o,
  output logic             osc_out_pin_oe,
  output logic             usb_tune_enable,
  // wake-up timer and monitors
  output logic [2:0]       wake_period,
  output logic             wake_irq,
  output logic             undervoltage_reset,
  output logic             aux_port_bit_one
);

  // ---------------------------------------------------------------
  // synchronisers for asynchronous inputs
  // ---------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {int_clk_level, osc_in_pin, ext_clock_stable, brownout_reset_event, undervoltage_below};
      sync2_q <= sync1_q;
    end
  end

  wire uv_s      = sync2_q[0];
  wire bor_s     = sync2_q[1];
  wire stable_s  = sync2_q[2];
  wire osc_in_s  = sync2_q[3];
  wire int_clk_s = sync2_q[4];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  clk_state_t  state_q;
  clk_state_t  state_d;
  logic        ext_mode_q;
  logic        ext_mode_d;
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic        cpu_run_q;
  logic        restart_q;
  logic        restart_d;
  logic        ld;
  logic [31:0] ld_val;
  logic        cnt_expire;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  wire         setup    = psel & ~penable;
  wire         access   = psel & penable & pready_q;
  wire         hit_cfg  = (paddr == CFG_OFFSET);
  wire         hit_stat = (paddr == STATUS_OFFSET);
  wire         cfg_wr   = access & pwrite & hit_cfg;
  wire         pending  = (state_q == ST_WAIT_STABLE) | (state_q == ST_DELAY) | (state_q == ST_LV_HOLD);
  // monitor sleeps in suspend to save power and wakes with the part
  wire         lv_active = ~cfg_q[BIT_LV_DISABLE] & (state_q != ST_SUSPENDED);  // [R4]
  // brownout always acts; undervoltage only while monitored
  wire         lv_event  = bor_s | (uv_s & lv_active);  // [R5] [R15]
  // a set of the select bit only matters from internal mode
  wire         switch_req = cfg_wr & pwdata[BIT_EXT_SEL] & ~ext_mode_q;  // [R8]

  logic        usb_tune_q;
  logic        lv_active_q;
  logic        aux_q;

  wire [7:0]   status_word = {2'b00, usb_tune_q, lv_active_q, aux_q, pending, cpu_run_q, ext_mode_q};
  wire [31:0]  rd_data     = hit_cfg  ? {24'h000000, cfg_q} :
                             hit_stat ? {24'h000000, status_word} : 32'h0000_0000;

  // answer in the first access cycle; read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit_cfg & ~hit_stat;
      prdata_q  <= setup ? rd_data : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // a reset event clears everything, including a write in the same cycle
  assign cfg_d = (lv_event | watchdog_reset_event) ? CFG_RESET :  // [R15]
                 cfg_wr ? pwdata[7:0] : cfg_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ---------------------------------------------------------------
  // clock sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    ext_mode_d = ext_mode_q;
    ld         = 1'b0;
    ld_val     = INT_WAKE_CYC;
    restart_d  = 1'b0;
    if (lv_event) begin
      // reloads while the supply stays low, so the hold counts from recovery
      state_d    = ST_LV_HOLD;  // [R5]
      ext_mode_d = 1'b0;        // [R15]
      ld         = 1'b1;
      ld_val     = START_CYCLES;
    end else if (watchdog_reset_event) begin
      // clock mode is kept; no supply settling delay
      state_d   = ST_RUN;       // [R15]
      restart_d = 1'b1;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (switch_req) begin
            ext_mode_d = 1'b1;  // [R8]
            state_d    = ST_WAIT_STABLE;
          end else if (suspend_enter) begin
            state_d = ST_SUSPENDED;
          end
        end
        ST_SUSPENDED: begin
          // select bit is sampled here and nowhere else
          if (wake_event) begin
            if (cfg_q[BIT_EXT_SEL]) begin
              ext_mode_d = 1'b1;  // [R9]
              state_d    = ST_WAIT_STABLE;
            end else begin
              ext_mode_d = 1'b0;  // [R11]
              ld         = 1'b1;
              ld_val     = INT_WAKE_CYC;  // [R2]
              state_d    = ST_DELAY;
            end
          end
        end
        ST_WAIT_STABLE: begin
          if (stable_s) begin
            ld      = 1'b1;  // [R10]
            ld_val  = cfg_q[BIT_RESUME_LONG] ? RESUME_LONG_CYCLES : RESUME_SHORT_CYCLES;  // [R1]
            state_d = ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (cnt_expire) begin
            state_d = ST_RUN;  // [R16]
          end
        end
        ST_LV_HOLD: begin
          if (cnt_expire) begin
            state_d   = ST_RUN;
            restart_d = 1'b1;  // [R5]
          end
        end
        default: begin
          state_d = ST_RUN;
        end
      endcase
    end
  end

  // reset comes up running on the internal oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_RUN;  // [R12]
      ext_mode_q <= 1'b0;
      cpu_run_q  <= 1'b1;
      restart_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      ext_mode_q <= ext_mode_d;
      cpu_run_q  <= (state_d == ST_RUN);  // [R16]
      restart_q  <= restart_d;
    end
  end

  delay_counter u_delay (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (ld),
    .load_value (ld_val),
    .busy       (),
    .expire     (cnt_expire)
  );

  // ---------------------------------------------------------------
  // oscillator and pin outputs
  // ---------------------------------------------------------------
  logic osc_int_en_q;
  logic osc_ext_en_q;
  logic clk_sel_q;
  logic out_o_q;
  logic out_oe_q;
  logic part_susp_q;
  logic wake_irq_q;

  wire  awake    = (state_q != ST_SUSPENDED);
  // the external amplifier owns the pin pair in external mode
  wire  out_oe_d = ~ext_mode_q;  // [R7]
  wire  out_o_d  = ~ext_mode_q & (cfg_q[BIT_CLKOUT_OFF] | int_clk_s);  // [R7] [R12]
  // tuning is only meaningful on the internal oscillator
  wire  tune_d   = cfg_q[BIT_USB_TUNE] & ~ext_mode_q & (usb_tune_q | usb_traffic_rx);  // [R6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_int_en_q <= 1'b1;
      osc_ext_en_q <= 1'b0;
      clk_sel_q    <= 1'b0;
      out_o_q      <= 1'b0;
      out_oe_q     <= 1'b1;
      usb_tune_q   <= 1'b0;
      lv_active_q  <= 1'b1;
      aux_q        <= 1'b0;
      part_susp_q  <= 1'b0;
      wake_irq_q   <= 1'b0;
    end else begin
      osc_int_en_q <= ~ext_mode_q & awake;  // [R8]
      osc_ext_en_q <= ext_mode_q & awake;
      clk_sel_q    <= ext_mode_q & (state_q != ST_WAIT_STABLE);  // [R10]
      out_o_q      <= out_o_d;
      out_oe_q     <= out_oe_d;
      usb_tune_q   <= tune_d;
      lv_active_q  <= lv_active;
      // plain level read, deliberately never routed to an interrupt
      aux_q        <= ~ext_mode_q & osc_in_s;  // [R13]
      part_susp_q  <= (state_d == ST_LV_HOLD);
      wake_irq_q   <= wake_timer_tick & wake_irq_enable;  // [R3]
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign cpu_run            = cpu_run_q;
  assign restart_pulse      = restart_q;
  assign partial_suspend    = part_susp_q;
  assign int_osc_enable     = osc_int_en_q;
  assign ext_osc_enable     = osc_ext_en_q;
  assign ext_clk_select     = clk_sel_q;
  assign osc_out_pin_o      = out_o_q;
  assign osc_out_pin_oe     = out_oe_q;
  assign usb_tune_enable    = usb_tune_q;
  assign wake_period        = cfg_q[WAKE_PERIOD_MSB:WAKE_PERIOD_LSB];  // [R3]
  assign wake_irq           = wake_irq_q;
  assign undervoltage_reset = lv_active_q;
  assign aux_port_bit_one   = aux_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_resume_delay_pick: assert property (@(posedge pclk) disable iff (!presetn)  // [R1]
    (state_q == ST_WAIT_STABLE && stable_s && !lv_event && !watchdog_reset_event) |->
      (ld && ld_val == (cfg_q[BIT_RESUME_LONG] ? RESUME_LONG_CYCLES : RESUME_SHORT_CYCLES)))
    else $error("resume delay not chosen from bit 7");

  a_int_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)  // [R2]
    (state_q == ST_SUSPENDED && wake_event && !cfg_q[BIT_EXT_SEL] && !lv_event && !watchdog_reset_event) |->
      (ld && ld_val == INT_WAKE_CYC) ##1 (state_q == ST_DELAY && !ext_mode_q))
    else $error("internal wake did not use the short delay");

  a_wake_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)  // [R3]
    wake_irq |-> $past(wake_timer_tick && wake_irq_enable))
    else $error("wake interrupt without enable");

  a_lv_monitor_off: assert property (@(posedge pclk) disable iff (!presetn)  // [R4]
    (cfg_q[BIT_LV_DISABLE] && uv_s && !bor_s && state_q == ST_RUN && !switch_req && !suspend_enter) |=> cpu_run)
    else $error("disabled monitor still stalled the cpu");

  a_lv_hold_restart: assert property (@(posedge pclk) disable iff (!presetn)  // [R5]
    (state_q == ST_LV_HOLD && cnt_expire && !lv_event) |=> (restart_pulse && cpu_run) ##1 !restart_pulse)
    else $error("no restart after start-up hold");

  a_tune_internal: assert property (@(posedge pclk) disable iff (!presetn)  // [R6]
    $rose(usb_tune_enable) |-> $past(usb_traffic_rx && !ext_mode_q && cfg_q[BIT_USB_TUNE]))
    else $error("usb tuning started without cause");

  a_out_pin_parked: assert property (@(posedge pclk) disable iff (!presetn)  // [R7]
    $past(!ext_mode_q && cfg_q[BIT_CLKOUT_OFF]) |-> (osc_out_pin_o && osc_out_pin_oe))
    else $error("output pin not held high");

  a_switch_halts: assert property (@(posedge pclk) disable iff (!presetn)  // [R8]
    (switch_req && state_q == ST_RUN && !lv_event && !watchdog_reset_event && !suspend_enter) |=>
      (!cpu_run && ext_mode_q) ##1 (!int_osc_enable && ext_osc_enable))
    else $error("switch to external did not halt the cpu");

  a_clear_no_effect: assert property (@(posedge pclk) disable iff (!presetn)  // [R9] [R11]
    (cfg_wr && !pwdata[BIT_EXT_SEL] && ext_mode_q && state_q == ST_RUN && !lv_event) |=> ext_mode_q)
    else $error("clearing the select bit changed the clock");

  a_aux_internal_only: assert property (@(posedge pclk) disable iff (!presetn)  // [R13]
    $past(ext_mode_q) |-> !aux_port_bit_one)
    else $error("aux bit live in external mode");

  a_watchdog_keeps_clock: assert property (@(posedge pclk) disable iff (!presetn)  // [R15]
    (watchdog_reset_event && !lv_event) |=> (!cfg_q[BIT_EXT_SEL] && ext_mode_q == $past(ext_mode_q) && restart_pulse))
    else $error("watchdog handling wrong");

  a_release_on_expire: assert property (@(posedge pclk) disable iff (!presetn)  // [R16]
    (state_q == ST_DELAY && !cnt_expire && !watchdog_reset_event) |=> !cpu_run)
    else $error("cpu released before delay expired");

endmodule
`default_nettype wire

// ---- testbench/ext_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model (
  // clock
  input  wire logic pclk,
  // control from the block and the bench
  input  wire logic osc_enable,
  input  wire logic slow_start,
  input  wire logic pin_drive,
  input  wire logic pin_value,
  // lines into the block
  output logic      stable,
  output logic      osc_in_pin
);
  logic [7:0] cnt_q;

  // start-up count: a resonator settles fast, a crystal takes much longer
  always @(posedge pclk) begin
    if (!osc_enable) begin
      cnt_q  <= 8'h00;
      stable <= 1'b0;
    end else if (cnt_q == (slow_start ? 8'h28 : 8'h05)) begin
      stable <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // weak pull-down while undriven; a ready clock enters on this pin only
  assign osc_in_pin = pin_drive ? pin_value : 1'b0;
endmodule
`default_nettype wire

// ---- testbench/clock_source_config_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_source_config_control_test
  import clock_source_pkg::*;
;
  localparam int SHORT_N = 20;
  localparam int LONG_N  = 50;
  localparam int START_N = 30;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lfsr_q, v;
  logic [31:0] pwdata, prdata;
  logic        suspend_enter, wake_event, watchdog_reset_event, usb_traffic_rx, wake_timer_tick;
  logic        wake_irq_enable, undervoltage_below, ext_clock_stable, osc_in_pin, int_clk_level;
  logic        cpu_run, restart_pulse, partial_suspend, int_osc_enable, ext_osc_enable, ext_clk_select;
  logic        osc_out_pin_o, osc_out_pin_oe, usb_tune_enable, wake_irq, undervoltage_reset;
  logic        aux_port_bit_one, slow_start, pin_drive, pin_value;
  logic [2:0]  wake_period;
  int          bad_count, cmp_count, n;
  typedef struct packed {logic rd; logic err; logic [31:0] data;} exp_t;
  exp_t        exp_q[$];
  exp_t        e;

  clock_source_config_control #(.RESUME_LONG_CYCLES(LONG_N), .RESUME_SHORT_CYCLES(SHORT_N),
    .START_CYCLES(START_N)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .suspend_enter(suspend_enter),
    .wake_event(wake_event), .watchdog_reset_event(watchdog_reset_event), .usb_traffic_rx(usb_traffic_rx),
    .wake_timer_tick(wake_timer_tick), .wake_irq_enable(wake_irq_enable),
    .undervoltage_below(undervoltage_below), .brownout_reset_event(1'b0), .ext_clock_stable(ext_clock_stable),
    .osc_in_pin(osc_in_pin), .int_clk_level(int_clk_level), .cpu_run(cpu_run), .restart_pulse(restart_pulse),
    .partial_suspend(partial_suspend), .int_osc_enable(int_osc_enable), .ext_osc_enable(ext_osc_enable),
    .ext_clk_select(ext_clk_select), .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe(osc_out_pin_oe),
    .usb_tune_enable(usb_tune_enable), .wake_period(wake_period), .wake_irq(wake_irq),
    .undervoltage_reset(undervoltage_reset), .aux_port_bit_one(aux_port_bit_one));

  ext_osc_model osc (.pclk(pclk), .osc_enable(ext_osc_enable), .slow_start(slow_start), .pin_drive(pin_drive),
    .pin_value(pin_value), .stable(ext_clock_stable), .osc_in_pin(osc_in_pin));

  // clock and a stand-in internal oscillator waveform
  always #2 pclk = ~pclk;
  always @(posedge pclk) int_clk_level <= presetn ? ~int_clk_level : 1'b0;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timed_out();
    bad_count++;
    $display("MISMATCH %0t wait ran out", $time);
    tally_and_finish();
  endtask

  // one apb transfer; the expected answer is queued for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    int k;
    exp_q.push_back('{rd: !w, err: err, data: d});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) timed_out();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle pulse on an event input: 0 suspend, 1 wake, 2 watchdog, 3 usb, 4 timer tick
  task automatic pulse(input int s);
    @(posedge pclk);
    case (s)
      0: suspend_enter <= 1'b1;
      1: wake_event <= 1'b1;
      2: watchdog_reset_event <= 1'b1;
      3: usb_traffic_rx <= 1'b1;
      default: wake_timer_tick <= 1'b1;
    endcase
    @(posedge pclk);
    {suspend_enter, wake_event, watchdog_reset_event, usb_traffic_rx, wake_timer_tick} <= 5'h00;
  endtask

  // bounded wait, sampled on the falling edge so updates have landed: 0 run, 1 restart, 2 stable
  task automatic wait_for(input int s, input int lim, output int cnt);
    cnt = 0;
    while ((s == 0 ? cpu_run : s == 1 ? restart_pulse : ext_clock_stable) !== 1'b1) begin
      @(negedge pclk);
      cnt++;
      if (cnt > lim) timed_out();
    end
  endtask

  task automatic irq_count(output int c);
    c = 0;
    repeat (4) begin
      @(negedge pclk);
      c += int'(wake_irq === 1'b1);
    end
  endtask
  // ---------------------------------------------------------------
  // answer monitor: oldest queued note against each completed transfer
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0, "unexpected answer");
      else begin
        e = exp_q.pop_front();
        chk(pslverr, e.err, "slave error");
        if (e.rd) chk(prdata, e.data, "read data");
      end
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {suspend_enter, wake_event, watchdog_reset_event, usb_traffic_rx, wake_timer_tick} = '0;
    {wake_irq_enable, undervoltage_below, slow_start, pin_drive, pin_value} = '0;
    lfsr_q = 8'h1b;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({cpu_run, int_osc_enable, osc_out_pin_oe, ext_clk_select}, 4'he, "reset mode");
    apb(1'b0, CFG_OFFSET, 32'h0, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h12, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 1'b1);
    $display("test reset done");
    // random field values, external select kept clear
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      v = lfsr_q & 8'hfe;
      apb(1'b1, CFG_OFFSET, {24'h0, v}, 1'b0);
      apb(1'b0, CFG_OFFSET, {24'h0, v}, 1'b0);
      chk(wake_period, v[6:4], "wake period");
      chk(undervoltage_reset, !v[3], "monitor state");
      if (v[1]) chk(osc_out_pin_o & osc_out_pin_oe, 1, "pin parked high");
      else chk(osc_out_pin_oe, 1, "clock driven out");
    end
    apb(1'b1, CFG_OFFSET, 32'h04, 1'b0);
    wake_irq_enable <= 1'b1;
    pulse(4);
    irq_count(n);
    chk(n, 1, "irq enabled");
    @(posedge pclk);
    wake_irq_enable <= 1'b0;
    pulse(4);
    irq_count(n);
    chk(n, 0, "irq gated");
    pulse(3);
    repeat (3) @(negedge pclk);
    chk(usb_tune_enable, 1, "usb tuning");
    @(posedge pclk);
    pin_drive <= 1'b1;
    pin_value <= 1'b1;
    repeat (5) @(negedge pclk);
    chk(aux_port_bit_one, 1, "aux pin");
    $display("test fields done");
    // switch to external, short resume delay
    apb(1'b1, CFG_OFFSET, 32'h01, 1'b0);
    repeat (3) @(negedge pclk);
    chk({cpu_run, int_osc_enable, ext_osc_enable}, 3'b001, "switch halts");
    wait_for(2, 100, n);
    wait_for(0, 300, n);
    chk(n >= SHORT_N && n <= SHORT_N + 8, 1, "short delay");
    chk({ext_clk_select, osc_out_pin_oe, aux_port_bit_one}, 3'b100, "ext mode");
    apb(1'b1, CFG_OFFSET, 32'h0, 1'b0);
    repeat (3) @(negedge pclk);
    chk(ext_clk_select, 1, "clear has no effect");
    pulse(0);
    repeat (5) @(negedge pclk);
    pulse(1);
    wait_for(0, 3000, n);
    chk(n >= 1990 && n <= 2010, 1, "internal wake");
    chk(ext_clk_select, 0, "back to internal");
    $display("test switch done");
    // crystal start-up with the long delay, then watchdog
    slow_start <= 1'b1;
    apb(1'b1, CFG_OFFSET, 32'h81, 1'b0);
    wait_for(2, 200, n);
    wait_for(0, 300, n);
    chk(n >= LONG_N && n <= LONG_N + 8, 1, "long delay");
    pulse(2);
    repeat (3) @(negedge pclk);
    apb(1'b0, CFG_OFFSET, 32'h0, 1'b0);
    chk(ext_clk_select, 1, "watchdog keeps clock");
    // undervoltage hold and restart
    @(posedge pclk);
    undervoltage_below <= 1'b1;
    repeat (10) @(negedge pclk);
    chk({partial_suspend, cpu_run, ext_clk_select}, 3'b100, "undervoltage hold");
    @(posedge pclk);
    undervoltage_below <= 1'b0;
    wait_for(1, 200, n);
    chk(n >= START_N, 1, "restart after start-up");
    // monitor switched off: a low supply must not stall the cpu
    apb(1'b1, CFG_OFFSET, 32'h08, 1'b0);
    undervoltage_below <= 1'b1;
    repeat (6) @(negedge pclk);
    chk({partial_suspend, cpu_run, undervoltage_reset}, 3'b010, "monitor off");
    @(posedge pclk);
    undervoltage_below <= 1'b0;
    $display("test resets done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
